// ===== shared/siu_pkg.sv
// constants and carrier types of the system integration unit
`default_nettype none
package siu_pkg;
	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [29:0] IDX_BREAK_STATUS  = 30'h0000FE00;
	localparam logic [29:0] IDX_BREAK_FLAG    = 30'h0000FE03;
	localparam logic [29:0] IDX_PENDING_LOW   = 30'h0000FE04;
	localparam logic [29:0] IDX_PENDING_MID   = 30'h0000FE05;
	localparam logic [29:0] IDX_PENDING_UPPER = 30'h0000FE06;
	localparam logic [29:0] IDX_PENDING_TOP   = 30'h0000FE07;
	localparam logic [29:0] IDX_CONFIG        = 30'h0000FE08;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_EXIT_WAIT      = 1;
	localparam int BIT_CLEAR_ENABLE   = 7;
	localparam int BIT_SHORT_RECOVERY = 0;
	localparam int BIT_WDOG_DISABLE   = 1;
	localparam int BIT_OSC_IN_STOP    = 2;
	// ---------------------------------------------------------------
	// reset values and counts
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_REG8       = 8'h00;
	localparam logic [2:0]  RST_CONFIG     = 3'h0;
	localparam logic [12:0] STOP_LONG_CYC  = 13'h1000;
	localparam logic [12:0] STOP_SHORT_CYC = 13'h0020;
	localparam int          NUM_SRC        = 24;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		LP_RUN     = 4'h1,
		LP_WAIT    = 4'h2,
		LP_STOP    = 4'h4,
		LP_RECOVER = 4'h8
	} siu_lp_t;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} siu_apb_req_t;
endpackage
`default_nettype wire

// ===== rtl/siu_top.sv
// system integration unit: pending status, break control, low-power sequencing
`timescale 1ns/1ps
`default_nettype none
module siu_top (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	// apb slave
	input  wire siu_pkg::siu_apb_req_t apb_req,
	output logic                      pready,
	output logic                      pslverr,
	output logic [31:0]               prdata,
	// interrupt sources and cpu
	input  wire logic [24:1]          irq_req,
	input  wire logic                 cpu_imask,
	output logic                      irq_take,
	output logic [4:0]                irq_source,
	// break
	input  wire logic                 break_irq,
	input  wire logic                 break_exit,
	output logic                      swi_vector,
	output logic                      break_state,
	output logic                      flag_clear_allow,
	// low power
	input  wire logic                 wait_exec,
	input  wire logic                 stop_exec,
	output logic                      imask_clear,
	output logic                      stack_start,
	output logic                      cpu_clk_en,
	output logic                      periph_clk_en,
	output logic                      bus_clk_en,
	output logic                      xtal_clk_en,
	output logic                      watchdog_run,
	output logic                      osc_keep_in_stop
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [24:1]      pend;
	logic             break_clear_enable;
	logic             break_exit_wait_indicator;
	logic [2:0]       cfg;
	siu_pkg::siu_lp_t lp;
	siu_pkg::siu_lp_t next_lp;
	logic [12:0]      rec_cnt;
	logic             rec_done;
	logic             break_q;
	logic             any_pend;
	logic             setup;
	logic             access;
	logic             hit;
	logic [29:0]      idx;
	logic [7:0]       rd_byte;

	assign idx    = apb_req.paddr[31:2];
	assign setup  = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable;

	// ---------------------------------------------------------------
	// pending mirror
	// ---------------------------------------------------------------
	// one sample stage only, so a withdrawn request clears next cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pend <= 24'h000000;
		end else begin
			pend <= irq_req;
		end
	end

	// ---------------------------------------------------------------
	// priority: source 1 highest, mask hides every source
	// ---------------------------------------------------------------
	always_comb begin
		irq_source = 5'h00;
		for (int i = siu_pkg::NUM_SRC; i >= 1; i--) begin
			if (pend[i]) begin
				irq_source = 5'(i);
			end
		end
	end
	assign any_pend = |pend;
	assign irq_take = any_pend & ~cpu_imask & (lp == siu_pkg::LP_RUN);

	// ---------------------------------------------------------------
	// apb decode and read path
	// ---------------------------------------------------------------
	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		case (idx)
			siu_pkg::IDX_PENDING_LOW: begin
				rd_byte = {pend[6:1], 2'h0};
			end
			siu_pkg::IDX_PENDING_MID: begin
				rd_byte = pend[14:7];
			end
			siu_pkg::IDX_PENDING_UPPER: begin
				rd_byte = pend[22:15];
			end
			siu_pkg::IDX_PENDING_TOP: begin
				rd_byte = {6'h00, pend[24:23]};
			end
			siu_pkg::IDX_BREAK_STATUS: begin
				rd_byte[siu_pkg::BIT_EXIT_WAIT] = break_exit_wait_indicator;
			end
			siu_pkg::IDX_BREAK_FLAG: begin
				rd_byte[siu_pkg::BIT_CLEAR_ENABLE] = break_clear_enable;
			end
			siu_pkg::IDX_CONFIG: begin
				rd_byte[2:0] = cfg;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// read data captured in setup, so access completes with no wait state
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= {24'h000000, rd_byte};
			pslverr <= ~hit;
		end
	end
	assign pready = access;

	// ---------------------------------------------------------------
	// software-written registers; pending registers take no write
	// ---------------------------------------------------------------
	logic wr;
	assign wr = access & apb_req.pwrite;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			break_clear_enable <= 1'b0;
			cfg                <= siu_pkg::RST_CONFIG;
		end else if (wr) begin
			if (idx == siu_pkg::IDX_BREAK_FLAG) begin
				break_clear_enable <= apb_req.pwdata[siu_pkg::BIT_CLEAR_ENABLE];
			end
			if (idx == siu_pkg::IDX_CONFIG) begin
				cfg <= apb_req.pwdata[2:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// break control
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			break_q     <= 1'b0;
			break_state <= 1'b0;
			swi_vector  <= 1'b0;
		end else begin
			break_q    <= break_irq;
			swi_vector <= break_irq & ~break_q;
			if (break_irq) begin
				break_state <= 1'b1;
			end else if (break_exit) begin
				break_state <= 1'b0;
			end
		end
	end

	// peripherals gate both steps of a two-step clear with this level,
	// so a first step taken before break cannot complete inside it
	assign flag_clear_allow = ~break_state | break_clear_enable;

	// set wins over a software clear in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			break_exit_wait_indicator <= 1'b0;
		end else if (lp == siu_pkg::LP_WAIT && break_irq) begin
			break_exit_wait_indicator <= 1'b1;
		end else if (wr && idx == siu_pkg::IDX_BREAK_STATUS &&
			!apb_req.pwdata[siu_pkg::BIT_EXIT_WAIT]) begin
			break_exit_wait_indicator <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// low-power sequencer
	// ---------------------------------------------------------------
	// counts core clock edges standing in for crystal clock edges
	assign rec_done = cfg[siu_pkg::BIT_SHORT_RECOVERY] ?
		(rec_cnt == siu_pkg::STOP_SHORT_CYC - 13'h0001) :
		(rec_cnt == siu_pkg::STOP_LONG_CYC - 13'h0001);

	always_comb begin
		next_lp = lp;
		case (lp)
			siu_pkg::LP_RUN: begin
				if (stop_exec) begin
					next_lp = siu_pkg::LP_STOP;
				end else if (wait_exec) begin
					next_lp = siu_pkg::LP_WAIT;
				end
			end
			siu_pkg::LP_WAIT: begin
				if (any_pend || break_irq) begin
					next_lp = siu_pkg::LP_RUN;
				end
			end
			siu_pkg::LP_STOP: begin
				if (any_pend) begin
					next_lp = siu_pkg::LP_RECOVER;
				end
			end
			siu_pkg::LP_RECOVER: begin
				if (rec_done) begin
					next_lp = siu_pkg::LP_RUN;
				end
			end
			default: begin
				next_lp = siu_pkg::LP_RUN;
			end
		endcase
	end

	// reset is asynchronous and forces run from any mode
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lp <= siu_pkg::LP_RUN;
		end else begin
			lp <= next_lp;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rec_cnt <= 13'h0000;
		end else if (lp == siu_pkg::LP_RECOVER) begin
			rec_cnt <= rec_cnt + 13'h0001;
		end else begin
			rec_cnt <= 13'h0000;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			imask_clear <= 1'b0;
			stack_start <= 1'b0;
		end else begin
			imask_clear <= (lp == siu_pkg::LP_RUN) & (wait_exec | stop_exec);
			stack_start <= (lp == siu_pkg::LP_WAIT && any_pend && !break_irq) ||
				(lp == siu_pkg::LP_RECOVER && rec_done);
		end
	end

	assign cpu_clk_en    = (lp == siu_pkg::LP_RUN);
	assign periph_clk_en = (lp == siu_pkg::LP_RUN) | (lp == siu_pkg::LP_WAIT);
	assign bus_clk_en    = (lp != siu_pkg::LP_STOP);
	assign xtal_clk_en   = (lp != siu_pkg::LP_STOP);
	// watchdog stays alive in wait; this enable also drops it in stop
	assign watchdog_run  = ~cfg[siu_pkg::BIT_WDOG_DISABLE] & (lp != siu_pkg::LP_STOP);
	// crystal users should leave short recovery clear unless this is set
	assign osc_keep_in_stop = cfg[siu_pkg::BIT_OSC_IN_STOP];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	AST_LOW_ZERO: assert property (setup && idx == siu_pkg::IDX_PENDING_LOW |=>
		prdata[1:0] == 2'h0 && prdata[7:2] == $past(pend[6:1]))
		else $error("low status bits wrong");
	AST_MID_MAP: assert property (setup && idx == siu_pkg::IDX_PENDING_MID |=>
		prdata[7:0] == $past(pend[14:7]))
		else $error("mid status mapping wrong");
	AST_TOP_ZERO: assert property (setup && idx == siu_pkg::IDX_PENDING_TOP |=>
		prdata[31:2] == 30'h00000000)
		else $error("top status upper bits not zero");
	AST_MIRROR: assert property (##1 pend == $past(irq_req))
		else $error("pending flag does not follow request");
	AST_PROTECT: assert property (break_state && !break_clear_enable |->
		!flag_clear_allow)
		else $error("flag clear allowed in protected break");
	AST_VECTOR: assert property ($rose(break_irq) |=> swi_vector ##1 !swi_vector)
		else $error("break did not force vector once");
	AST_IMASK: assert property (lp == siu_pkg::LP_RUN && wait_exec |=>
		imask_clear && lp == siu_pkg::LP_WAIT)
		else $error("wait did not clear mask");
	AST_WAIT_CLK: assert property (lp == siu_pkg::LP_WAIT |->
		!cpu_clk_en && periph_clk_en)
		else $error("wait clock gating wrong");
	AST_WAKE: assert property (lp == siu_pkg::LP_WAIT && any_pend && !break_irq |=>
		stack_start && cpu_clk_en)
		else $error("wait wakeup stacking late");
	AST_BREAK_EXIT_WAIT_INDICATOR: assert property (lp == siu_pkg::LP_WAIT && break_irq |=>
		break_exit_wait_indicator && lp == siu_pkg::LP_RUN && !stack_start)
		else $error("break exit of wait not flagged");
	AST_STOP_CLK: assert property (lp == siu_pkg::LP_STOP |->
		!bus_clk_en && !xtal_clk_en && rec_cnt == 13'h0000)
		else $error("stop did not gate clocks");
	AST_SHORT_REC: assert property ($rose(lp == siu_pkg::LP_RECOVER) &&
		cfg[siu_pkg::BIT_SHORT_RECOVERY] && $stable(cfg) |-> ##32 stack_start)
		else $error("short recovery length wrong");
	AST_NO_EARLY: assert property (lp == siu_pkg::LP_RECOVER && !rec_done |=>
		!stack_start)
		else $error("stacking before recovery end");
	AST_PRIO: assert property (irq_take |-> pend[irq_source] &&
		((pend & ((24'h000001 << (irq_source - 5'h01)) - 24'h000001)) == 24'h000000))
		else $error("wrong source chosen");

	COV_WAIT_WAKE: cover property (lp == siu_pkg::LP_WAIT ##1 stack_start);
	COV_STOP_REC:  cover property (lp == siu_pkg::LP_RECOVER ##1 lp == siu_pkg::LP_RUN);
	COV_BREAK_CLR: cover property (break_state && break_clear_enable);
	COV_READ_TOP:  cover property (access && idx == siu_pkg::IDX_PENDING_TOP);
endmodule
`default_nettype wire

// ===== bench/siu_cpu_model.sv
// behavioural model of the cpu core that sits beside the system integration unit
`timescale 1ns/1ps
`default_nettype none
module siu_cpu_model (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// commands from the bench
	input  wire logic do_wait,
	input  wire logic do_stop,
	input  wire logic do_cli,
	// answers from the unit
	input  wire logic imask_clear,
	input  wire logic stack_start,
	input  wire logic swi_vector,
	// towards the unit
	output logic      cpu_imask,
	output logic      wait_exec,
	output logic      stop_exec
);
	// ---------------------------------------------------------------
	// global mask
	// ---------------------------------------------------------------
	// set out of reset and on every stacking, as the core does
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cpu_imask <= 1'b1;
		end else if (stack_start || swi_vector) begin
			cpu_imask <= 1'b1;
		end else if (imask_clear || do_cli) begin
			cpu_imask <= 1'b0;
		end
	end
	// one-cycle instruction strobes, timed by the bench
	assign wait_exec = do_wait;
	assign stop_exec = do_stop;
endmodule
`default_nettype wire

// ===== bench/test_siu_top.sv
// self-checking bench of the system integration unit
`timescale 1ns/1ps
`default_nettype none
module test_siu_top;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic                  core_clk    = 1'b0;
	logic                  rstn        = 1'b0;
	siu_pkg::siu_apb_req_t apb_req     = '0;
	logic [24:1]           irq_req     = 24'h000000;
	logic                  break_irq   = 1'b0;
	logic                  break_exit  = 1'b0;
	logic                  do_wait     = 1'b0;
	logic                  do_stop     = 1'b0;
	logic                  do_cli      = 1'b0;
	logic                  pready, pslverr, irq_take, swi_vector, break_state;
	logic                  flag_clear_allow, imask_clear, stack_start, cpu_clk_en;
	logic                  periph_clk_en, bus_clk_en, xtal_clk_en, watchdog_run;
	logic                  osc_keep_in_stop, cpu_imask, wait_exec, stop_exec;
	logic [31:0]           prdata;
	logic [31:0]           rd;
	logic [4:0]            irq_source;
	logic                  er;
	int                    n;
	int                    miscompares = 0;
	int                    check_count = 0;

	siu_top dut_u (.core_clk, .rstn, .apb_req, .pready, .pslverr, .prdata, .irq_req,
		.cpu_imask, .irq_take, .irq_source, .break_irq, .break_exit, .swi_vector,
		.break_state, .flag_clear_allow, .wait_exec, .stop_exec, .imask_clear,
		.stack_start, .cpu_clk_en, .periph_clk_en, .bus_clk_en, .xtal_clk_en,
		.watchdog_run, .osc_keep_in_stop);
	siu_cpu_model model_u (.core_clk, .rstn, .do_wait, .do_stop, .do_cli, .imask_clear,
		.stack_start, .swi_vector, .cpu_imask, .wait_exec, .stop_exec);

	always #50 core_clk = ~core_clk;

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// only the watchdog ends a wait for pready
	task automatic apb(input logic wr, input logic [29:0] idx, input logic [7:0] wd);
		@(posedge core_clk);
		apb_req <= '{1'b1, 1'b0, wr, {idx, 2'h0}, {24'h000000, wd}};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	// order: break_exit, do_cli, do_stop, do_wait
	task automatic strobe(input logic [3:0] k);
		@(posedge core_clk);
		{break_exit, do_cli, do_stop, do_wait} <= k;
		@(posedge core_clk);
		{break_exit, do_cli, do_stop, do_wait} <= 4'h0;
		@(negedge core_clk);
	endtask

	// sampled on the falling edge so a one-cycle pulse is never missed
	task automatic count_stack();
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (stack_start !== 1'b1 && n < 5000);
	endtask

	function automatic logic [31:0] pend_word(input int s, input int r);
		logic [31:0] w;
		w = 32'h00000000;
		if (s >= 1 && s <= 6 && r == 0) w[s + 1] = 1'b1;
		else if (s >= 7 && s <= 14 && r == 1) w[s - 7] = 1'b1;
		else if (s >= 15 && s <= 22 && r == 2) w[s - 15] = 1'b1;
		else if (s >= 23 && r == 3) w[s - 23] = 1'b1;
		return w;
	endfunction

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_pending();
		logic [24:0] one_hot;
		for (int s = 0; s <= 24; s++) begin
			one_hot = 25'h0000001 << s;
			@(posedge core_clk);
			irq_req <= one_hot[24:1];
			repeat (2) @(posedge core_clk);
			for (int r = 0; r < 4; r++) begin
				apb(1'b0, siu_pkg::IDX_PENDING_LOW + 30'(r), 8'h00);
				chk(rd, pend_word(s, r));
			end
		end
		irq_req <= 24'h000040;
		apb(1'b1, siu_pkg::IDX_PENDING_MID, 8'h00);
		apb(1'b0, siu_pkg::IDX_PENDING_MID, 8'h00);
		chk(rd, 32'h00000001);
		irq_req <= 24'h010100;
		@(posedge core_clk);
		@(negedge core_clk);
		chk({irq_take, irq_source}, 6'h09);
		strobe(4'h4);
		chk({irq_take, irq_source}, 6'h29);
		apb(1'b0, 30'h0000FE10, 8'h00);
		chk(er, 1'b1);
		chk(rd, 32'h00000000);
		irq_req <= 24'h000000;
		$display("pending test done");
	endtask

	task automatic t_break();
		@(posedge core_clk);
		break_irq <= 1'b1;
		n = 0;
		repeat (4) begin
			@(negedge core_clk);
			if (swi_vector === 1'b1) n++;
		end
		chk(32'(n), 32'h00000001);
		chk({break_state, flag_clear_allow}, 2'h2);
		apb(1'b1, siu_pkg::IDX_BREAK_FLAG, 8'h80);
		apb(1'b0, siu_pkg::IDX_BREAK_FLAG, 8'h00);
		chk(flag_clear_allow, 1'b1);
		chk(rd, 32'h00000080);
		apb(1'b1, siu_pkg::IDX_BREAK_FLAG, 8'h00);
		@(negedge core_clk);
		chk(flag_clear_allow, 1'b0);
		@(posedge core_clk);
		break_irq <= 1'b0;
		strobe(4'h8);
		chk({break_state, flag_clear_allow}, 2'h1);
		$display("break test done");
	endtask

	task automatic t_wait();
		strobe(4'h1);
		chk({imask_clear, cpu_clk_en, periph_clk_en, watchdog_run}, 4'hB);
		@(posedge core_clk);
		irq_req <= 24'h000800;
		count_stack();
		chk(32'(n), 32'h00000003);
		chk(cpu_clk_en, 1'b1);
		@(posedge core_clk);
		irq_req <= 24'h000000;
		strobe(4'h1);
		@(posedge core_clk);
		break_irq <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk({cpu_clk_en, stack_start}, 2'h2);
		@(posedge core_clk);
		break_irq <= 1'b0;
		strobe(4'h8);
		apb(1'b0, siu_pkg::IDX_BREAK_STATUS, 8'h00);
		chk(rd, 32'h00000002);
		apb(1'b1, siu_pkg::IDX_BREAK_STATUS, 8'h00);
		apb(1'b0, siu_pkg::IDX_BREAK_STATUS, 8'h00);
		chk(rd, 32'h00000000);
		$display("wait test done");
	endtask

	task automatic t_stop(input logic [7:0] cfg, input int cyc);
		apb(1'b1, siu_pkg::IDX_CONFIG, cfg);
		@(negedge core_clk);
		chk({osc_keep_in_stop, watchdog_run}, {cfg[2], ~cfg[1]});
		strobe(4'h2);
		chk({cpu_clk_en, periph_clk_en, bus_clk_en, xtal_clk_en}, 4'h0);
		@(posedge core_clk);
		irq_req <= 24'h800000;
		count_stack();
		chk(32'(n), 32'(cyc + 3));
		@(posedge core_clk);
		irq_req <= 24'h000000;
		$display("stop test done");
	endtask

	task automatic t_reset();
		strobe(4'h2);
		@(posedge core_clk);
		rstn <= 1'b0;
		@(negedge core_clk);
		chk({cpu_clk_en, bus_clk_en, xtal_clk_en}, 3'h7);
		@(posedge core_clk);
		rstn <= 1'b1;
		apb(1'b0, siu_pkg::IDX_CONFIG, 8'h00);
		chk(rd, 32'h00000000);
		$display("reset test done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// about 5000 cycles are needed; allow four times that
	initial begin
		#2000000;
		miscompares++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		t_pending();
		t_break();
		t_wait();
		t_stop(8'h05, 32);
		t_stop(8'h02, 4096);
		t_reset();
		finish_test();
	end
endmodule
`default_nettype wire
